// ---- dv/sgr_chip_src.sv ----
// chip stream source standing in for the radio front end demodulator
`timescale 1ns/1ps
module sgr_chip_src (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        go,
  input  wire logic [63:0] frame,
  input  wire logic [6:0]  nchips,
  output      logic        chip_valid,
  output      logic        chip_in,
  output      logic        busy
);
  logic [63:0] sh_ff;
  logic [6:0]  left_ff;
  logic [1:0]  div_ff;

  assign busy = (left_ff != 7'h00);

  // ==========================================================================
  // one chip every four clocks, frame bit 0 first; between chips the line
  // toggles so a stale value is never mistaken for data
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sh_ff      <= 64'h0;
      left_ff    <= 7'h00;
      div_ff     <= 2'h0;
      chip_valid <= 1'b0;
      chip_in    <= 1'b0;
    end
    else
    begin
      chip_valid <= 1'b0;
      chip_in    <= ~chip_in;
      if (go)
      begin
        sh_ff   <= frame;
        left_ff <= nchips;
        div_ff  <= 2'h0;
      end
      else if (busy)
      begin
        div_ff <= div_ff + 2'h1;
        if (div_ff == 2'h3)
        begin
          chip_valid <= 1'b1;
          chip_in    <= sh_ff[0];
          sh_ff      <= sh_ff >> 1;
          left_ff    <= left_ff - 7'h01;
        end
      end
    end
  end
endmodule

// ---- dv/sgr_gap_resync_props.sv ----
// port assertions for the start-pattern gap resync block
`timescale 1ns/1ps
module sgr_gap_resync_chk (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       cfg_sel_b,
  input wire logic       first_half_match,
  input wire logic       freq_hold,
  input wire logic       phase_correct_pulse,
  input wire logic [2:0] fine_phase_correction,
  input wire logic       clock_restart_pulse,
  input wire logic       post_gap_settle,
  input wire logic       compare_active,
  input wire logic       second_half_found,
  input wire logic       resync_fail,
  input wire logic       preslice_off,
  input wire logic [1:0] preslice_hysteresis,
  input wire logic [4:0] preslice_threshold
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // ==========================================================================
  // sequence relations
  property p_hold_cause;
    $rose(freq_hold) |-> $past(first_half_match);
  endproperty
  a_hold_cause: assert property (p_hold_cause)
    else $error("freq hold rose without a first half match");

  property p_hold_end;
    $fell(freq_hold) |-> post_gap_settle && (phase_correct_pulse || clock_restart_pulse);
  endproperty
  a_hold_end: assert property (p_hold_end)
    else $error("gap end without settle and resync pulse");

  property p_one_resync;
    !(phase_correct_pulse && clock_restart_pulse);
  endproperty
  a_one_resync: assert property (p_one_resync)
    else $error("phase correction and restart together");

  property p_phase_pulse;
    phase_correct_pulse |=> !phase_correct_pulse;
  endproperty
  a_phase_pulse: assert property (p_phase_pulse)
    else $error("phase correction longer than one cycle");

  property p_fine_hold;
    $changed(fine_phase_correction) |-> phase_correct_pulse;
  endproperty
  a_fine_hold: assert property (p_fine_hold)
    else $error("fine phase changed without correction");

  property p_found_window;
    second_half_found |-> $past(compare_active) && !compare_active && !resync_fail;
  endproperty
  a_found_window: assert property (p_found_window)
    else $error("second half found outside window");

  property p_fail_window;
    resync_fail |-> $past(compare_active) && !compare_active;
  endproperty
  a_fail_window: assert property (p_fail_window)
    else $error("resync fail outside window");

  property p_settle_first;
    !(post_gap_settle && (compare_active || freq_hold));
  endproperty
  a_settle_first: assert property (p_settle_first)
    else $error("settle overlaps hold or compare");

  property p_preslice;
    (reg_wr_en && reg_addr == sgr_pkg::PRESLICE_A_OFFSET && !cfg_sel_b) ##1 !cfg_sel_b
      |-> {preslice_off, preslice_hysteresis, preslice_threshold} == $past(reg_wdata);
  endproperty
  a_preslice: assert property (p_preslice)
    else $error("pre-slicer fields do not follow write");
endmodule

bind sgr_gap_resync sgr_gap_resync_chk chk_u (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .cfg_sel_b(cfg_sel_b), .first_half_match(first_half_match),
  .freq_hold(freq_hold), .phase_correct_pulse(phase_correct_pulse),
  .fine_phase_correction(fine_phase_correction), .clock_restart_pulse(clock_restart_pulse),
  .post_gap_settle(post_gap_settle), .compare_active(compare_active),
  .second_half_found(second_half_found), .resync_fail(resync_fail),
  .preslice_off(preslice_off), .preslice_hysteresis(preslice_hysteresis),
  .preslice_threshold(preslice_threshold)
);

// ---- dv/tb_sgr_gap_resync.sv ----
// self-checking bench for the start-pattern gap resync block
`timescale 1ns/1ps
module tb_sgr_gap_resync;
  logic        clk_sys, rst_b, reg_wr_en, cfg_sel_b, chip_valid, chip_in;
  logic        first_half_match, go, busy, freq_hold, phase_correct_pulse;
  logic        clock_restart_pulse, post_gap_settle, compare_active, preslice_off;
  logic        second_half_found, resync_fail, tracking, phase_readjust_pulse;
  logic [1:0]  preslice_hysteresis;
  logic [2:0]  fine_phase_correction;
  logic [4:0]  second_half_length, preslice_threshold;
  logic [6:0]  nchips;
  logic [7:0]  reg_addr, reg_wdata;
  logic [15:0] second_half_pattern;
  logic [63:0] frame;
  int          num_errors, checks, n_chips, n_hold, n_phase, n_restart;
  int          n_found, n_fail, n_readj, end_chip, pc_chip;

  sgr_gap_resync dut_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .cfg_sel_b(cfg_sel_b), .chip_valid(chip_valid),
    .chip_in(chip_in), .first_half_match(first_half_match),
    .second_half_length(second_half_length), .second_half_pattern(second_half_pattern),
    .freq_hold(freq_hold), .phase_correct_pulse(phase_correct_pulse),
    .fine_phase_correction(fine_phase_correction), .clock_restart_pulse(clock_restart_pulse),
    .post_gap_settle(post_gap_settle), .compare_active(compare_active),
    .second_half_found(second_half_found), .resync_fail(resync_fail),
    .manchester_phase_tracking(tracking), .phase_readjust_pulse(phase_readjust_pulse),
    .preslice_off(preslice_off), .preslice_hysteresis(preslice_hysteresis),
    .preslice_threshold(preslice_threshold)
  );

  sgr_chip_src src_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .go(go), .frame(frame), .nchips(nchips),
    .chip_valid(chip_valid), .chip_in(chip_in), .busy(busy)
  );

  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;

  // ==========================================================================
  // per-scenario tallies; chip numbers are remembered where pulses land
  always @(posedge clk_sys)
  begin
    n_chips   += chip_valid;
    n_hold    += freq_hold;
    n_phase   += phase_correct_pulse;
    n_restart += clock_restart_pulse;
    n_found   += second_half_found;
    n_fail    += resync_fail;
    n_readj   += phase_readjust_pulse;
    if (second_half_found || resync_fail)
      end_chip = n_chips;
    if (phase_correct_pulse || clock_restart_pulse)
      pc_chip = n_chips;
  end

  // ==========================================================================
  // comparison, verdict and register write
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_wr_en = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #1;
    reg_wr_en = 1'b0;
  endtask

  // configure set A, flag the first half and stream chips; bounded wait
  task automatic run(input logic [7:0] mode, input logic [7:0] gap,
                     input logic [63:0] fr, input logic [6:0] n);
    int i;
    wr(sgr_pkg::MODE_A_OFFSET, mode);
    wr(sgr_pkg::GAP_A_OFFSET, gap);
    {n_chips, n_hold, n_phase, n_restart, n_found, n_fail, n_readj, end_chip, pc_chip} = '0;
    @(posedge clk_sys);
    #1;
    first_half_match = 1'b1;
    go               = 1'b1;
    frame            = fr;
    nchips           = n;
    @(posedge clk_sys);
    #1;
    first_half_match = 1'b0;
    go               = 1'b0;
    for (i = 0; i < 400 && busy !== 1'b0; i++)
      @(posedge clk_sys);
    if (i == 400)
    begin
      num_errors++;
      test_done();
    end
    repeat (8) @(posedge clk_sys);
    #1;
  endtask

  initial
  begin
    {reg_wr_en, cfg_sel_b, first_half_match, go} = 4'h0;
    reg_addr            = 8'h00;
    reg_wdata           = 8'h00;
    frame               = 64'h0;
    nchips              = 7'h00;
    second_half_length  = 5'h04;
    second_half_pattern = 16'h000b;
    num_errors          = 0;
    checks              = 0;
    rst_b               = 1'b0;
    repeat (16) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    // register map, both sets, an unmapped address
    check({preslice_off, preslice_hysteresis, preslice_threshold}, 8'h00);
    check(tracking, 1'b0);
    wr(sgr_pkg::PRESLICE_A_OFFSET, 8'h32);
    check({preslice_off, preslice_hysteresis, preslice_threshold}, 8'h32);
    wr(sgr_pkg::PRESLICE_B_OFFSET, 8'hff);
    cfg_sel_b = 1'b1;
    wr(8'hb6, 8'h00);
    check({preslice_off, preslice_hysteresis, preslice_threshold}, 8'hff);
    cfg_sel_b = 1'b0;
    wr(sgr_pkg::MODE_A_OFFSET, 8'h04);
    check({preslice_off, preslice_hysteresis, preslice_threshold}, 8'h32);
    check(tracking, 1'b1);
    // mode zero, gap 8, pattern completes on the first chip allowed
    run(8'h02, 8'h45, 64'h1a000, 7'd22);
    check(n_hold > 0, 1'b1);
    check(pc_chip, 8);
    check(n_phase, 1);
    check(n_restart, 0);
    check(fine_phase_correction, 3'h5);
    check(n_found, 1);
    check(end_chip, 17);
    check(n_readj, 0);
    // pattern one chip too early is not taken; window closes at 8+4+11
    run(8'h02, 8'h45, 64'hd000, 7'd26);
    check(n_found, 0);
    check(n_fail, 1);
    check(end_chip, 23);
    // mode one, gap 10: restart, fine phase ignored
    run(8'h82, 8'h57, 64'h0, 7'd30);
    check(n_restart, 1);
    check(n_phase, 0);
    check(fine_phase_correction, 3'h5);
    check(pc_chip, 10);
    check(end_chip, 25);
    // short gap: no hold, window still runs
    run(8'h02, 8'h20, 64'h0, 7'd24);
    check(n_hold, 0);
    check(end_chip, 19);
    // not gap mode: first half flag ignored
    run(8'h00, 8'h45, 64'h0, 7'd24);
    check(n_hold + n_phase + n_fail + n_found, 0);
    // phase tracking on 1001 and 0110 chip changes
    run(8'h06, 8'h45, 64'h69696969, 7'd32);
    check(n_readj > 0, 1'b1);
    // mid-run reset returns every register to zero
    rst_b = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    check({preslice_off, preslice_hysteresis, preslice_threshold}, 8'h00);
    check(tracking, 1'b0);
    test_done();
  end
endmodule

// ---- verilog/sgr_chip_counter.sv ----
// chip counter advanced by the recovered data clock enable
`timescale 1ns/1ps
module sgr_chip_counter (
  clk_sys,
  rst_b,
  clear,
  step,
  count
);
  input  wire logic                    clk_sys;
  input  wire logic                    rst_b;
  input  wire logic                    clear;
  input  wire logic                    step;
  output      logic [sgr_pkg::CNT_W-1:0] count;

  typedef struct packed {
    logic [sgr_pkg::CNT_W-1:0] cnt;
  } sgr_cnt_state_type;

  sgr_cnt_state_type st_ff;
  sgr_cnt_state_type nxt_st;

  // saturate so a stalled window never wraps back into range
  always_comb
  begin
    nxt_st = st_ff;
    if (clear)
    begin
      nxt_st.cnt = '0;
    end
    else if (step && (st_ff.cnt != {sgr_pkg::CNT_W{1'b1}}))
    begin
      nxt_st.cnt = st_ff.cnt + 6'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign count = st_ff.cnt;
endmodule

// ---- verilog/sgr_gap_resync.sv ----
// gap hold, resync and second-half window for the telegram start pattern detector
`timescale 1ns/1ps
// What this block does
// RULE_01 - gap mode only for odd or long gaps
// RULE_02 - hold frequency during gaps of eight chips plus
// RULE_03 - mode zero: keep frequency, fine phase correction
// RULE_04 - mode one: restart recovery, ignore fine phase
// RULE_05 - allow five to six chips settling after gap
// RULE_06 - compare start at gap plus six chips
// RULE_07 - time gap with pre-gap recovered chip clock
// RULE_08 - abandon at gap plus length plus eleven
// RULE_09 - whole pattern must lie inside window
// RULE_10 - comparison register cleared to zeros after gap
// RULE_11 - software sets no-gap validation window formula
// RULE_12 - software sets gap validation window maximum
// RULE_13 - mode bit 7 selects recovery restart
// RULE_14 - mode bit 2 enables Manchester phase tracking
// RULE_15 - gap bits 7:3 hold coarse half-bit gap
// RULE_16 - gap bits 2:0 fine phase, restart off
// RULE_17 - preslice bit 7 disables jammer pre-slicer
// RULE_18 - software programs hysteresis 01, threshold 10010
// RULE_19 - second half length capped at sixteen chips
// RULE_20 - chip counter starts after first half match
module sgr_gap_resync (
  clk_sys,
  rst_b,
  reg_wr_en,
  reg_addr,
  reg_wdata,
  cfg_sel_b,
  chip_valid,
  chip_in,
  first_half_match,
  second_half_length,
  second_half_pattern,
  freq_hold,
  phase_correct_pulse,
  fine_phase_correction,
  clock_restart_pulse,
  post_gap_settle,
  compare_active,
  second_half_found,
  resync_fail,
  manchester_phase_tracking,
  phase_readjust_pulse,
  preslice_off,
  preslice_hysteresis,
  preslice_threshold
);
  input  wire logic        clk_sys;
  input  wire logic        rst_b;
  input  wire logic        reg_wr_en;
  input  wire logic [7:0]  reg_addr;
  input  wire logic [7:0]  reg_wdata;
  input  wire logic        cfg_sel_b;
  input  wire logic        chip_valid;
  input  wire logic        chip_in;
  input  wire logic        first_half_match;
  input  wire logic [4:0]  second_half_length;
  input  wire logic [15:0] second_half_pattern;
  output      logic        freq_hold;
  output      logic        phase_correct_pulse;
  output      logic [2:0]  fine_phase_correction;
  output      logic        clock_restart_pulse;
  output      logic        post_gap_settle;
  output      logic        compare_active;
  output      logic        second_half_found;
  output      logic        resync_fail;
  output      logic        manchester_phase_tracking;
  output      logic        phase_readjust_pulse;
  output      logic        preslice_off;
  output      logic [1:0]  preslice_hysteresis;
  output      logic [4:0]  preslice_threshold;

  // ==========================================================================
  // state
  typedef struct packed {
    sgr_pkg::sgr_state_type state;
    logic [7:0]             mode_a;
    logic [7:0]             gap_a;
    logic [7:0]             mode_b;
    logic [7:0]             gap_b;
    logic [7:0]             psl_a;
    logic [7:0]             psl_b;
    logic                   eval;
    logic [3:0]             hist;
    logic                   hold;
    logic                   settle;
    logic                   cmp;
    logic                   ph_pulse;
    logic [2:0]             ph_val;
    logic                   rst_pulse;
    logic                   found;
    logic                   fail;
    logic                   readj;
  } sgr_main_state_type;

  sgr_main_state_type st_ff;
  sgr_main_state_type nxt_st;

  logic [7:0]               sel_mode;
  logic [7:0]               sel_gap;
  logic [4:0]               coarse_gap_length;
  logic                     resync_restart_select;
  logic                     gap_mode;
  logic [4:0]               half_len;
  logic [5:0]               gap_chips;
  logic [5:0]               start_pos;
  logic [5:0]               full_pos;
  logic [5:0]               stop_pos;
  logic [5:0]               chip_cnt;
  logic                     cnt_clear;
  logic                     cnt_step;
  logic                     sh_clear;
  logic                     sh_shift;
  logic                     pat_hit;

  // ==========================================================================
  // active configuration set
  always_comb
  begin
    sel_mode = cfg_sel_b ? st_ff.mode_b : st_ff.mode_a;
    sel_gap  = cfg_sel_b ? st_ff.gap_b : st_ff.gap_a;
  end

  // half-bit gap steps are chip steps, so the coarse field is a chip count
  assign coarse_gap_length     = sel_gap[sgr_pkg::COARSE_GAP_MSB:
                                         sgr_pkg::COARSE_GAP_LSB]; // RULE_15
  assign resync_restart_select = sel_mode[sgr_pkg::RESTART_SELECT_BIT]; // RULE_13
  assign gap_mode = sel_mode[sgr_pkg::DETECT_MODE_MSB:sgr_pkg::DETECT_MODE_LSB]
                    == sgr_pkg::GAP_DETECT_MODE; // RULE_01
  assign gap_chips = {1'b0, coarse_gap_length};

  // unused length codes above sixteen are treated as sixteen
  assign half_len = (second_half_length > sgr_pkg::MAX_HALF_LENGTH) ?
                    sgr_pkg::MAX_HALF_LENGTH : second_half_length; // RULE_19

  // window edges do not depend on lock-in or resync mode
  assign start_pos = gap_chips + sgr_pkg::START_OFFSET; // RULE_06
  assign full_pos  = start_pos + {1'b0, half_len} - 6'h01; // RULE_09
  assign stop_pos  = gap_chips + {1'b0, half_len} + sgr_pkg::STOP_OFFSET; // RULE_08

  // ==========================================================================
  // chip counter and comparison shift register
  // the counter only moves on chip_valid, which keeps the pre-gap rate in the gap
  assign cnt_step  = chip_valid && (st_ff.state != sgr_pkg::ST_SEARCH); // RULE_07
  assign cnt_clear = (st_ff.state == sgr_pkg::ST_SEARCH) && gap_mode
                     && first_half_match; // RULE_20
  assign sh_clear  = (st_ff.state == sgr_pkg::ST_GAP) && (chip_cnt >= gap_chips); // RULE_10
  assign sh_shift  = chip_valid && ((st_ff.state == sgr_pkg::ST_SETTLE) ||
                                    (st_ff.state == sgr_pkg::ST_COMPARE));

  sgr_chip_counter u_counter (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clear   (cnt_clear),
    .step    (cnt_step),
    .count   (chip_cnt)
  );

  sgr_pattern_match u_match (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clear   (sh_clear),
    .shift_en(sh_shift),
    .chip    (chip_in),
    .pattern (second_half_pattern),
    .length  (half_len),
    .hit     (pat_hit)
  );

  // ==========================================================================
  // register writes, sequence control and outputs
  always_comb
  begin
    nxt_st           = st_ff;
    nxt_st.ph_pulse  = 1'b0;
    nxt_st.rst_pulse = 1'b0;
    nxt_st.found     = 1'b0;
    nxt_st.fail      = 1'b0;
    nxt_st.readj     = 1'b0;
    nxt_st.eval      = chip_valid;

    // write-only registers from the serial port
    if (reg_wr_en)
    begin
      case (reg_addr)
        sgr_pkg::MODE_A_OFFSET:     nxt_st.mode_a = reg_wdata;
        sgr_pkg::GAP_A_OFFSET:      nxt_st.gap_a  = reg_wdata;
        sgr_pkg::MODE_B_OFFSET:     nxt_st.mode_b = reg_wdata;
        sgr_pkg::GAP_B_OFFSET:      nxt_st.gap_b  = reg_wdata;
        sgr_pkg::PRESLICE_A_OFFSET: nxt_st.psl_a  = reg_wdata;
        sgr_pkg::PRESLICE_B_OFFSET: nxt_st.psl_b  = reg_wdata;
        default:                    nxt_st.mode_a = st_ff.mode_a;
      endcase
    end

    // phase tracking looks for 1001 or 0110 in the chip stream
    if (chip_valid)
    begin
      nxt_st.hist = {st_ff.hist[2:0], chip_in};
      if (sel_mode[sgr_pkg::PHASE_TRACKING_BIT] &&
          (({st_ff.hist[2:0], chip_in} == 4'h9) || ({st_ff.hist[2:0], chip_in} == 4'h6)))
      begin
        nxt_st.readj = 1'b1; // RULE_14
      end
    end

    case (st_ff.state)
      sgr_pkg::ST_SEARCH:
      begin
        nxt_st.hold   = 1'b0;
        nxt_st.settle = 1'b0;
        nxt_st.cmp    = 1'b0;
        if (gap_mode && first_half_match)
        begin
          nxt_st.state = sgr_pkg::ST_GAP;
          // short gaps are not held; the window timing still applies
          nxt_st.hold  = (gap_chips >= sgr_pkg::MIN_HOLD_GAP); // RULE_02
        end
      end
      sgr_pkg::ST_GAP:
      begin
        if (chip_cnt >= gap_chips)
        begin
          nxt_st.hold   = 1'b0;
          nxt_st.settle = 1'b1; // RULE_05
          nxt_st.state  = sgr_pkg::ST_SETTLE;
          if (resync_restart_select)
          begin
            nxt_st.rst_pulse = 1'b1; // RULE_04
          end
          else
          begin
            nxt_st.ph_pulse = 1'b1; // RULE_03
            nxt_st.ph_val   = sel_gap[sgr_pkg::FINE_PHASE_MSB:sgr_pkg::FINE_PHASE_LSB]; // RULE_16
          end
        end
      end
      sgr_pkg::ST_SETTLE:
      begin
        // settle spans the same chips that precede the compare start
        if (chip_cnt >= gap_chips + sgr_pkg::SETTLE_CHIPS)
        begin
          nxt_st.settle = 1'b0;
        end
        if (chip_cnt >= start_pos)
        begin
          nxt_st.state = sgr_pkg::ST_COMPARE; // RULE_06
          nxt_st.cmp   = 1'b1;
        end
      end
      sgr_pkg::ST_COMPARE:
      begin
        if (st_ff.eval)
        begin
          if (pat_hit && (chip_cnt >= full_pos) && (chip_cnt <= stop_pos))
          begin
            nxt_st.found = 1'b1; // RULE_09
            nxt_st.cmp   = 1'b0;
            nxt_st.state = sgr_pkg::ST_SEARCH;
          end
          else if (chip_cnt >= stop_pos)
          begin
            nxt_st.fail  = 1'b1; // RULE_08
            nxt_st.cmp   = 1'b0;
            nxt_st.state = sgr_pkg::ST_SEARCH;
          end
        end
      end
      default:
      begin
        nxt_st.state = sgr_pkg::ST_SEARCH;
      end
    endcase
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff        <= '0;
      st_ff.state  <= sgr_pkg::ST_SEARCH;
      st_ff.mode_a <= sgr_pkg::MODE_RESET;
      st_ff.mode_b <= sgr_pkg::MODE_RESET;
      st_ff.gap_a  <= sgr_pkg::GAP_RESET;
      st_ff.gap_b  <= sgr_pkg::GAP_RESET;
      st_ff.psl_a  <= sgr_pkg::PRESLICE_RESET;
      st_ff.psl_b  <= sgr_pkg::PRESLICE_RESET;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // outputs
  assign freq_hold                 = st_ff.hold; // RULE_02
  assign phase_correct_pulse       = st_ff.ph_pulse;
  assign fine_phase_correction     = st_ff.ph_val;
  assign clock_restart_pulse       = st_ff.rst_pulse;
  assign post_gap_settle           = st_ff.settle;
  assign compare_active            = st_ff.cmp;
  assign second_half_found         = st_ff.found;
  assign resync_fail               = st_ff.fail;
  assign manchester_phase_tracking = sel_mode[sgr_pkg::PHASE_TRACKING_BIT]; // RULE_14
  assign phase_readjust_pulse      = st_ff.readj;

  // pre-slicer fields pass straight to the analog slicer control
  always_comb
  begin
    if (cfg_sel_b)
    begin
      preslice_off        = st_ff.psl_b[sgr_pkg::PRESLICE_OFF_BIT]; // RULE_17
      preslice_hysteresis = st_ff.psl_b[sgr_pkg::PRESLICE_HYST_MSB:sgr_pkg::PRESLICE_HYST_LSB];
      preslice_threshold  = st_ff.psl_b[sgr_pkg::PRESLICE_THR_MSB:sgr_pkg::PRESLICE_THR_LSB];
    end
    else
    begin
      preslice_off        = st_ff.psl_a[sgr_pkg::PRESLICE_OFF_BIT]; // RULE_17
      preslice_hysteresis = st_ff.psl_a[sgr_pkg::PRESLICE_HYST_MSB:sgr_pkg::PRESLICE_HYST_LSB];
      preslice_threshold  = st_ff.psl_a[sgr_pkg::PRESLICE_THR_MSB:sgr_pkg::PRESLICE_THR_LSB];
    end
  end
endmodule

// ---- verilog/sgr_pattern_match.sv ----
// serial chip shift register with length-masked compare
`timescale 1ns/1ps
module sgr_pattern_match (
  clk_sys,
  rst_b,
  clear,
  shift_en,
  chip,
  pattern,
  length,
  hit
);
  input  wire logic                         clk_sys;
  input  wire logic                         rst_b;
  input  wire logic                         clear;
  input  wire logic                         shift_en;
  input  wire logic                         chip;
  input  wire logic [sgr_pkg::PATTERN_W-1:0] pattern;
  input  wire logic [4:0]                   length;
  output      logic                         hit;

  typedef struct packed {
    logic [sgr_pkg::PATTERN_W-1:0] shreg;
  } sgr_match_state_type;

  sgr_match_state_type st_ff;
  sgr_match_state_type nxt_st;
  logic [sgr_pkg::PATTERN_W-1:0] mask;

  // clearing fills with zero chips, newest chip enters at bit 0
  always_comb
  begin
    nxt_st = st_ff;
    if (clear)
    begin
      nxt_st.shreg = '0;
    end
    else if (shift_en)
    begin
      nxt_st.shreg = {st_ff.shreg[sgr_pkg::PATTERN_W-2:0], chip};
    end
  end

  // only the low length chips take part
  always_comb
  begin
    for (int i = 0; i < sgr_pkg::PATTERN_W; i++)
    begin
      mask[i] = (5'(i) < length);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign hit = ((st_ff.shreg ^ pattern) & mask) == '0;
endmodule

// ---- verilog/sgr_pkg.sv ----
// constants, register map and state type for the start-pattern gap resync block
package sgr_pkg;

  // ==========================================================================
  // register offsets (byte addresses on the serial register port)
  localparam logic [7:0] MODE_A_OFFSET     = 8'h82;
  localparam logic [7:0] GAP_A_OFFSET      = 8'h85;
  localparam logic [7:0] MODE_B_OFFSET     = 8'ha2;
  localparam logic [7:0] GAP_B_OFFSET      = 8'ha5;
  localparam logic [7:0] PRESLICE_A_OFFSET = 8'hb4;
  localparam logic [7:0] PRESLICE_B_OFFSET = 8'hb5;

  // ==========================================================================
  // reset values
  localparam logic [7:0] MODE_RESET        = 8'h00;
  localparam logic [7:0] GAP_RESET         = 8'h00;
  localparam logic [7:0] PRESLICE_RESET    = 8'h00;

  // ==========================================================================
  // field positions
  localparam int RESTART_SELECT_BIT        = 7;
  localparam int PHASE_TRACKING_BIT        = 2;
  localparam int DETECT_MODE_MSB           = 1;
  localparam int DETECT_MODE_LSB           = 0;
  localparam int COARSE_GAP_MSB            = 7;
  localparam int COARSE_GAP_LSB            = 3;
  localparam int FINE_PHASE_MSB            = 2;
  localparam int FINE_PHASE_LSB            = 0;
  localparam int PRESLICE_OFF_BIT          = 7;
  localparam int PRESLICE_HYST_MSB         = 6;
  localparam int PRESLICE_HYST_LSB         = 5;
  localparam int PRESLICE_THR_MSB          = 4;
  localparam int PRESLICE_THR_LSB          = 0;

  // detection mode code that runs the two halves in sequence with a gap
  localparam logic [1:0] GAP_DETECT_MODE   = 2'b10;

  // ==========================================================================
  // chip counts
  localparam int          CNT_W            = 6;
  localparam logic [5:0]  MIN_HOLD_GAP     = 6'h08;  // chips
  localparam logic [5:0]  SETTLE_CHIPS     = 6'h06;  // post gap settle, 5..6 chips
  localparam logic [5:0]  START_OFFSET     = 6'h06;  // compare start, gap + 6..8
  localparam logic [5:0]  STOP_OFFSET      = 6'h0b;  // compare stop, gap + len + 11
  localparam logic [4:0]  MAX_HALF_LENGTH  = 5'h10;  // sixteen chips
  localparam int          PATTERN_W        = 16;

  typedef enum logic [1:0] {
    ST_SEARCH,
    ST_GAP,
    ST_SETTLE,
    ST_COMPARE
  } sgr_state_type;

endpackage
